// >>> hw/cmd_spacing_pkg.sv
package cmd_spacing_pkg;

  // ------------------------------------------------------------
  // Command encoding seen by the user port
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_BURST_STOP,
    CMD_MODE_SET,
    CMD_REFRESH,
    CMD_SELFREF_ENTER,
    CMD_SELFREF_EXIT,
    CMD_POWERDOWN_ENTER,
    CMD_POWERDOWN_EXIT
  } cmd_t;

  // Pin command codes {rasN, casN, weN}
  localparam logic [2:0] PIN_NOP       = 3'h7;
  localparam logic [2:0] PIN_ACTIVATE  = 3'h3;
  localparam logic [2:0] PIN_READ      = 3'h5;
  localparam logic [2:0] PIN_WRITE     = 3'h4;
  localparam logic [2:0] PIN_PRECHARGE = 3'h2;
  localparam logic [2:0] PIN_STOP      = 3'h6;
  localparam logic [2:0] PIN_MODE_SET  = 3'h0;
  localparam logic [2:0] PIN_REFRESH   = 3'h1;

  // ------------------------------------------------------------
  // Spacing counts in module clock cycles
  // ------------------------------------------------------------
  localparam int WRITE_TO_PRECHARGE_BASE = 3;
  localparam int WRITE_TO_READ_BASE      = 2;
  localparam int READ_TO_WRITE_BASE_CL3  = 2;
  localparam int READ_TO_WRITE_BASE_CL35 = 3;
  localparam int STOP_TO_WRITE_CL3       = 2;
  localparam int STOP_TO_WRITE_CL35      = 3;
  localparam int STOP_TO_FLOAT_CL3       = 3;
  localparam int PRECHARGE_TO_FLOAT_CL3  = 3;
  localparam int WRITE_DATA_LATENCY      = 2;
  localparam int MODE_SET_GAP            = 2;
  localparam int SELFREF_EXIT_NONREAD    = 10;
  localparam int SELFREF_EXIT_READ       = 200;
  localparam int POWERDOWN_EXIT_GAP      = 1;
  localparam int CLK_EN_MIN_WIDTH        = 1;
  localparam int REGISTER_STAGE_DELAY    = 1;
  localparam int CNT_W                   = 8;

  // Mode register burst length field (bits 2:0)
  localparam int        BL_FIELD_LSB = 0;
  localparam logic [2:0] BL_RESET    = 3'h1; // burst of 2
  localparam int        BANKS        = 4;

endpackage

// >>> hw/gap_if.sv
`timescale 1ns/1ps
// Bundle of one spacing counter: load request and done flag
interface gap_if;
  import cmd_spacing_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic             done;
  modport owner   (output load, output count, input done);
  modport counter (input load, input count, output done);
endinterface

// >>> hw/gap_counter.sv
`timescale 1ns/1ps
// Down counter; done is high once the loaded gap has fully elapsed
module gap_counter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  gap_if.counter    gap
);
  import cmd_spacing_pkg::*;

  logic [CNT_W-1:0] left_q;
  logic [CNT_W-1:0] left_d;

  // Reload wins over the running count
  always_comb begin
    left_d = left_q;
    if (gap.load) begin
      left_d = gap.count;
    end else if (left_q != '0) begin
      left_d = left_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      left_q <= '0;
    end else begin
      left_q <= left_d;
    end
  end

  // Done comes from the register alone, so a command's ready never loops back through its load
  assign gap.done = (left_q == '0);
endmodule // gap_counter

// >>> hw/rdimm_command_spacing.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: After a write to a bank, precharge of that bank waits 3 + BL/2 cycles.
// R2: After a read to a bank, precharge of that bank waits BL/2 cycles.
// R3: A read follows a write by at least 2 + BL/2 cycles.
// R4: A write follows a burst stop by 2 cycles at latency 3 and 3 at latency 3.5.
// R5: The module floats its data lines 3 or 3.5 cycles after a burst stop.
// R6: A write follows a read by 2 + BL/2 (latency 3) or 3 + BL/2 (latency 3.5).
// R7: The module floats its data outputs 3 or 3.5 cycles after a precharge cuts a read.
// R8: Write data starts on the bus two cycles after the write command.
// R9: Activate or mode set waits two cycles after a mode set.
// R10: Any non-read command waits ten cycles after self refresh exit.
// R11: A read waits two hundred cycles after self refresh exit.
// R12: A command waits one cycle after clock enable rises to leave power down.
// R13: Each clock enable level is held at least one full cycle.
// R14: Latency at the connector is the component latency plus one cycle.
// R15: Clock enable low enters power down or self refresh, high exits it.
// R16: While module reset is asserted resetN is low; clkEn, csN and the command pins are held high.
// R17: Spacing is counted in module clock cycles with the programmed burst length.
module rdimm_command_spacing (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // User command port
  input  wire logic                     cmdValid,
  output logic                          cmdReady,
  input  wire cmd_spacing_pkg::cmd_t    cmdCode,
  input  wire logic [1:0]               cmdBank,
  input  wire logic [12:0]              cmdAddr,
  input  wire logic                     latencyHalf,
  // Write data start strobe
  output logic                          wrDataStart,
  // Module pins, then the data bus free flag
  output logic                          resetN,
  output logic                          clkEn,
  output logic                          csN,
  output logic                          rasN,
  output logic                          casN,
  output logic                          weN,
  output logic [1:0]                    bankSel,
  output logic [12:0]                   addr,
  output logic                          dataBusFree
);
  import cmd_spacing_pkg::*;

  // ------------------------------------------------------------
  // Spacing counters
  // ------------------------------------------------------------
  gap_if gWr2Rd ();
  gap_if gRd2Wr ();
  gap_if gStop ();
  gap_if gMode ();
  gap_if gSrN ();
  gap_if gSrR ();
  gap_if gCke ();
  gap_if gPre [BANKS] ();
  gap_if gFloat ();

  gap_counter uWr2Rd (.clk(clk), .reset(reset), .gap(gWr2Rd));
  gap_counter uRd2Wr (.clk(clk), .reset(reset), .gap(gRd2Wr));
  gap_counter uStop  (.clk(clk), .reset(reset), .gap(gStop));
  gap_counter uMode  (.clk(clk), .reset(reset), .gap(gMode));
  gap_counter uSrN   (.clk(clk), .reset(reset), .gap(gSrN));
  gap_counter uSrR   (.clk(clk), .reset(reset), .gap(gSrR));
  gap_counter uCke   (.clk(clk), .reset(reset), .gap(gCke));
  gap_counter uFloat (.clk(clk), .reset(reset), .gap(gFloat));

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : gBank
      gap_counter uPre (.clk(clk), .reset(reset), .gap(gPre[b]));
    end
  endgenerate

  // Counts are loaded with gap-1 so done rises exactly gap cycles later
  function automatic logic [CNT_W-1:0] gapCount(input int cycles);
    gapCount = CNT_W'(cycles - 1);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_ACTIVE, ST_POWERDOWN, ST_SELFREF} pwr_t;
  pwr_t        pwr_q, pwr_d;
  logic [2:0]  burstLen_q, burstLen_d;
  logic        cke_q, cke_d;
  logic [2:0]  pinCmd_q, pinCmd_d;
  logic [1:0]  bank_q, bank_d;
  logic [12:0] addr_q, addr_d;
  logic [1:0]  wrPipe_q, wrPipe_d;
  logic        busy_q, busy_d;
  logic        resetN_q;
  logic [BANKS-1:0] preOk;
  logic [CNT_W-1:0] halfBl;
  logic        allowed;
  logic        take;

  // Half the programmed burst: 2->1, 4->2, 8->4 [R17]
  assign halfBl = CNT_W'(4'h1 << (burstLen_q - 3'h1));

  generate
    for (b = 0; b < BANKS; b++) begin : gOk
      assign preOk[b] = gPre[b].done;
    end
  endgenerate

  // Spacing check for the presented command
  always_comb begin
    allowed = 1'b0;
    case (cmdCode)
      CMD_NOP:           allowed = 1'b1;
      CMD_READ:          allowed = gWr2Rd.done && gSrR.done && gCke.done
                                   && pwr_q == ST_ACTIVE;                      // [R3] [R11]
      CMD_WRITE:         allowed = gRd2Wr.done && gStop.done && gSrN.done && gCke.done
                                   && pwr_q == ST_ACTIVE;                      // [R4] [R6]
      CMD_PRECHARGE:     allowed = (cmdAddr[10] ? &preOk : preOk[cmdBank])
                                   && gSrN.done && gCke.done && pwr_q == ST_ACTIVE; // [R1] [R2]
      CMD_ACTIVATE,
      CMD_MODE_SET:      allowed = gMode.done && gSrN.done && gCke.done
                                   && pwr_q == ST_ACTIVE;                      // [R9] [R10] [R12]
      CMD_BURST_STOP,
      CMD_REFRESH:       allowed = gSrN.done && gCke.done && pwr_q == ST_ACTIVE; // [R10]
      CMD_SELFREF_ENTER,
      CMD_POWERDOWN_ENTER: allowed = gCke.done && gSrN.done && pwr_q == ST_ACTIVE; // [R13]
      CMD_SELFREF_EXIT:  allowed = gCke.done && pwr_q == ST_SELFREF;           // [R13]
      CMD_POWERDOWN_EXIT: allowed = gCke.done && pwr_q == ST_POWERDOWN;        // [R13]
      default:           allowed = 1'b0;
    endcase
  end

  assign cmdReady = allowed && resetN_q;
  assign take     = cmdValid && cmdReady && cmdCode != CMD_NOP;

  // ------------------------------------------------------------
  // Counter loads
  // ------------------------------------------------------------
  always_comb begin
    gWr2Rd.load  = take && cmdCode == CMD_WRITE;
    gWr2Rd.count = gapCount(WRITE_TO_READ_BASE) + halfBl;                     // [R3]
    gRd2Wr.load  = take && cmdCode == CMD_READ;
    gRd2Wr.count = gapCount(latencyHalf ? READ_TO_WRITE_BASE_CL35
                                        : READ_TO_WRITE_BASE_CL3) + halfBl;   // [R6]
    gStop.load   = take && cmdCode == CMD_BURST_STOP;
    gStop.count  = gapCount(latencyHalf ? STOP_TO_WRITE_CL35 : STOP_TO_WRITE_CL3); // [R4]
    gMode.load   = take && cmdCode == CMD_MODE_SET;
    gMode.count  = gapCount(MODE_SET_GAP);                                    // [R9]
    gSrN.load    = take && cmdCode == CMD_SELFREF_EXIT;
    gSrN.count   = gapCount(SELFREF_EXIT_NONREAD);                            // [R10]
    gSrR.load    = take && cmdCode == CMD_SELFREF_EXIT;
    gSrR.count   = gapCount(SELFREF_EXIT_READ);                               // [R11]
    gCke.load    = take && (cmdCode == CMD_SELFREF_ENTER || cmdCode == CMD_SELFREF_EXIT
                   || cmdCode == CMD_POWERDOWN_ENTER || cmdCode == CMD_POWERDOWN_EXIT);
    gCke.count   = gapCount(CLK_EN_MIN_WIDTH + POWERDOWN_EXIT_GAP);           // [R12] [R13]
    // Bus floats a fixed time after stop or precharge; half cycle rounds up
    gFloat.load  = take && (cmdCode == CMD_BURST_STOP || cmdCode == CMD_PRECHARGE);
    gFloat.count = gapCount((cmdCode == CMD_BURST_STOP ? STOP_TO_FLOAT_CL3
                            : PRECHARGE_TO_FLOAT_CL3) + int'(latencyHalf)
                            + REGISTER_STAGE_DELAY);                          // [R5] [R7] [R14]
  end

  generate
    for (b = 0; b < BANKS; b++) begin : gPreLoad
      always_comb begin
        gPre[b].load  = take && cmdBank == 2'(b)
                        && (cmdCode == CMD_WRITE || cmdCode == CMD_READ);
        gPre[b].count = (cmdCode == CMD_WRITE)
                        ? gapCount(WRITE_TO_PRECHARGE_BASE) + halfBl         // [R1]
                        : halfBl - 1'b1;                                      // [R2]
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Pin state next values
  // ------------------------------------------------------------
  always_comb begin
    pwr_d      = pwr_q;
    burstLen_d = burstLen_q;
    cke_d      = cke_q;
    pinCmd_d   = PIN_NOP;
    bank_d     = bank_q;
    addr_d     = addr_q;
    // Pipe starts from the write on the pins, so data trails what the module sees by two
    wrPipe_d   = {wrPipe_q[0], pinCmd_q == PIN_WRITE};                       // [R8]
    busy_d     = busy_q;
    if (take) begin
      bank_d = cmdBank;
      addr_d = cmdAddr;
      case (cmdCode)
        CMD_ACTIVATE:  pinCmd_d = PIN_ACTIVATE;
        CMD_READ: begin
          pinCmd_d = PIN_READ;
          busy_d   = 1'b1;
        end
        CMD_WRITE:     pinCmd_d = PIN_WRITE;
        CMD_PRECHARGE: pinCmd_d = PIN_PRECHARGE;
        CMD_BURST_STOP: pinCmd_d = PIN_STOP;
        CMD_MODE_SET: begin
          pinCmd_d = PIN_MODE_SET;
          if (cmdBank == 2'h0) begin
            burstLen_d = cmdAddr[BL_FIELD_LSB +: 3];                          // [R17]
          end
        end
        CMD_REFRESH:   pinCmd_d = PIN_REFRESH;
        CMD_SELFREF_ENTER: begin
          pinCmd_d = PIN_REFRESH;
          cke_d    = 1'b0;                                                    // [R15]
          pwr_d    = ST_SELFREF;
        end
        CMD_POWERDOWN_ENTER: begin
          cke_d = 1'b0;                                                       // [R15]
          pwr_d = ST_POWERDOWN;
        end
        CMD_SELFREF_EXIT,
        CMD_POWERDOWN_EXIT: begin
          cke_d = 1'b1;                                                       // [R15]
          pwr_d = ST_ACTIVE;
        end
        default: pinCmd_d = PIN_NOP;
      endcase
    end
    // Busy clears once the float and read-to-write counters are both done and no new read is taken
    if (gFloat.done && !(take && cmdCode == CMD_READ) && gFloat.load == 1'b0
        && busy_q && !gRd2Wr.done) begin
      busy_d = busy_q;
    end else if (gFloat.done && gRd2Wr.done && !(take && cmdCode == CMD_READ)) begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_q      <= ST_ACTIVE;
      burstLen_q <= BL_RESET;
      cke_q      <= 1'b1;
      pinCmd_q   <= PIN_NOP;
      bank_q     <= 2'h0;
      addr_q     <= 13'h0000;
      wrPipe_q   <= 2'h0;
      busy_q     <= 1'b0;
      resetN_q   <= 1'b0;                                                     // [R16]
    end else begin
      pwr_q      <= pwr_d;
      burstLen_q <= burstLen_d;
      cke_q      <= cke_d;
      pinCmd_q   <= pinCmd_d;
      bank_q     <= bank_d;
      addr_q     <= addr_d;
      wrPipe_q   <= wrPipe_d;
      busy_q     <= busy_d;
      resetN_q   <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign resetN      = resetN_q;
  assign clkEn       = cke_q;
  assign csN         = (pinCmd_q == PIN_NOP);
  assign {rasN, casN, weN} = pinCmd_q;
  assign bankSel     = bank_q;
  assign addr        = addr_q;
  assign wrDataStart = wrPipe_q[1];                                           // [R8]
  assign dataBusFree = !busy_q;
endmodule // rdimm_command_spacing

// >>> sim/rdimm_command_spacing_sva.sv
`timescale 1ns/1ps
module rdimm_command_spacing_sva (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // User command port
  input wire logic                  cmdValid,
  input wire logic                  cmdReady,
  input wire cmd_spacing_pkg::cmd_t cmdCode,
  input wire logic [1:0]            cmdBank,
  input wire logic [12:0]           cmdAddr,
  input wire logic                  latencyHalf,
  // Observed outputs
  input wire logic                  wrDataStart,
  input wire logic                  clkEn,
  input wire logic                  csN
);
  import cmd_spacing_pkg::*;
  // ------
  // Cycles since last write, read, stop, self refresh exit
  // ------
  logic       take;
  logic [3:0] hit;
  logic [7:0] since_q [4];
  logic [7:0] blHalf_q;
  logic [1:0] wrBank_q;
  logic [1:0] rdBank_q;
  assign take = cmdValid && cmdReady && cmdCode != CMD_NOP;
  assign hit  = {4{take}} & {cmdCode == CMD_SELFREF_EXIT, cmdCode == CMD_BURST_STOP,
                             cmdCode == CMD_READ, cmdCode == CMD_WRITE};
  // Counts saturate so a long idle never wraps into a false short gap
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++)
      since_q[i] <= reset ? 8'hFF : hit[i] ? 8'h01 : since_q[i] + {7'h00, since_q[i] != 8'hFF};
    if (reset)
      blHalf_q <= 8'h01;
    else if (take && cmdCode == CMD_MODE_SET && cmdBank == 2'h0)
      blHalf_q <= 8'h01 << (cmdAddr[BL_FIELD_LSB +: 3] - 3'h1);
    if (hit[0])
      wrBank_q <= cmdBank;
    if (hit[1])
      rdBank_q <= cmdBank;
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take(cmd_t c); take && cmdCode == c; endsequence
  sequence s_pre(logic [1:0] b); s_take(CMD_PRECHARGE) ##0 (cmdAddr[10] || cmdBank == b); endsequence
  property p_wr_pre; s_pre(wrBank_q) |-> since_q[0] >= 3 + blHalf_q; endproperty
  property p_rd_pre; s_pre(rdBank_q) |-> since_q[1] >= blHalf_q; endproperty
  property p_wr_rd; s_take(CMD_READ) |-> since_q[0] >= 2 + blHalf_q; endproperty
  property p_stop_wr; s_take(CMD_WRITE) |-> since_q[2] >= (latencyHalf ? 3 : 2); endproperty
  property p_rd_wr; s_take(CMD_WRITE) |-> since_q[1] >= (latencyHalf ? 3 : 2) + blHalf_q; endproperty
  // Pins carry the write one edge after the take; data starts two edges after that
  property p_wr_data; s_take(CMD_WRITE) |-> ##3 wrDataStart; endproperty
  property p_srx_rd; s_take(CMD_READ) |-> since_q[3] >= 200; endproperty
  property p_pdx; $rose(clkEn) |-> csN ##1 csN; endproperty
  property p_cke_hold; $changed(clkEn) |=> $stable(clkEn); endproperty
  a_wr_pre: assert property (p_wr_pre) else $error("write to precharge gap");
  a_rd_pre: assert property (p_rd_pre) else $error("read to precharge gap");
  a_wr_rd: assert property (p_wr_rd) else $error("write to read gap");
  a_stop_wr: assert property (p_stop_wr) else $error("stop to write gap");
  a_rd_wr: assert property (p_rd_wr) else $error("read to write gap");
  a_wr_data: assert property (p_wr_data) else $error("write data start");
  a_srx_rd: assert property (p_srx_rd) else $error("self refresh to read");
  a_pdx: assert property (p_pdx) else $error("power down exit gap");
  a_cke_hold: assert property (p_cke_hold) else $error("clock enable width");
endmodule // rdimm_command_spacing_sva
bind rdimm_command_spacing rdimm_command_spacing_sva u_rdimm_command_spacing_sva (.clk, .reset,
  .cmdValid, .cmdReady, .cmdCode, .cmdBank, .cmdAddr, .latencyHalf, .wrDataStart, .clkEn, .csN);

// >>> sim/ddr_dimm_model.sv
`timescale 1ns/1ps
module ddr_dimm_model (
  // Clock and mode
  input wire logic        clk,
  input wire logic        latencyHalf,
  // Module pins
  input wire logic        resetN,
  input wire logic        csN,
  input wire logic        rasN,
  input wire logic        casN,
  input wire logic        weN,
  input wire logic [1:0]  bankSel,
  input wire logic [12:0] addr,
  // Data bus state
  output logic            dqOe,
  output logic            wrCapture
);
  import cmd_spacing_pkg::*;
  logic [2:0] pinCmd;
  logic [3:0] rdWait_q, rdLeft_q, float_q, blHalf_q;
  logic [1:0] wrPipe_q;
  assign pinCmd    = csN ? PIN_NOP : {rasN, casN, weN};
  assign dqOe      = resetN && rdWait_q == 4'h0 && rdLeft_q != 4'h0;
  assign wrCapture = resetN && wrPipe_q[1];
  // Half cycles cannot show on one edge, so 3.5 floats at 4: pessimistic
  always_ff @(posedge clk) begin
    if (!resetN) begin
      rdWait_q <= 4'h0;
      rdLeft_q <= 4'h0;
      float_q  <= 4'h0;
      wrPipe_q <= 2'h0;
      blHalf_q <= 4'h1;
    end else begin
      wrPipe_q <= {wrPipe_q[0], pinCmd == PIN_WRITE};
      if (rdWait_q != 4'h0)
        rdWait_q <= rdWait_q - 4'h1;
      else if (rdLeft_q != 4'h0)
        rdLeft_q <= rdLeft_q - 4'h1;
      if (float_q == 4'h1)
        rdLeft_q <= 4'h0;
      if (float_q != 4'h0)
        float_q <= float_q - 4'h1;
      if (pinCmd == PIN_READ) begin
        rdWait_q <= latencyHalf ? 4'h3 : 4'h2;
        rdLeft_q <= blHalf_q;
      end
      if (pinCmd == PIN_STOP || pinCmd == PIN_PRECHARGE)
        float_q <= latencyHalf ? 4'h4 : 4'h3;
      if (pinCmd == PIN_MODE_SET && bankSel == 2'h0)
        blHalf_q <= 4'h1 << (addr[1:0] - 2'h1);
    end
  end
endmodule // ddr_dimm_model

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  import cmd_spacing_pkg::*;
  logic        clk, reset, cmdValid, cmdReady, latencyHalf, wrDataStart, resetN;
  logic        clkEn, csN, rasN, casN, weN, dqOe, dataBusFree, expCke, wrCapture;
  cmd_t        cmdCode;
  logic [1:0]  cmdBank, bankSel;
  logic [12:0] cmdAddr, addr;
  int          n_errors = 0;
  int          compares = 0;
  rdimm_command_spacing u_rdimm_command_spacing (.clk, .reset, .cmdValid, .cmdReady, .cmdCode,
    .cmdBank, .cmdAddr, .latencyHalf, .wrDataStart, .resetN, .clkEn, .csN, .rasN, .casN, .weN,
    .bankSel, .addr, .dataBusFree);
  ddr_dimm_model u_ddr_dimm_model (.clk, .latencyHalf, .resetN, .csN, .rasN, .casN, .weN,
    .bankSel, .addr, .dqOe, .wrCapture);
  // ------
  // Common tasks
  // ------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic fail(input string msg);
    n_errors++;
    $display("BAD %0t %s", $time, msg);
  endtask
  task automatic finish_test();
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(input logic lh);
    reset       <= 1'b1;
    cmdValid    <= 1'b0;
    cmdCode     <= CMD_NOP;
    latencyHalf <= lh;
    repeat (10) @(posedge clk);
    compares++;
    if (resetN !== 1'b0 || cmdReady !== 1'b0 || dataBusFree !== 1'b1) fail("in reset");
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    if (resetN !== 1'b1) fail("reset release");
    expCke = 1'b1;
  endtask
  // Holds the request until taken; gap counts edges since the previous take
  task automatic issue(input cmd_t c, input logic [1:0] b, input logic [12:0] a, input int gap);
    int n;
    cmdCode  <= c;
    cmdBank  <= b;
    cmdAddr  <= a;
    cmdValid <= 1'b1;
    for (n = 1; n < 400; n++) begin
      #1;
      if (n == 1) begin
        compares++;
        if (clkEn !== expCke) fail("clock enable level");
      end
      if (cmdReady === 1'b1) break;
      @(posedge clk);
    end
    @(posedge clk);
    // Look just after the take edge, once the registered pins have settled
    #1;
    compares++;
    if (csN !== (c == CMD_POWERDOWN_ENTER || c == CMD_SELFREF_EXIT || c == CMD_POWERDOWN_EXIT)
        || bankSel !== b || addr !== a) fail("pin command");
    if (c == CMD_ACTIVATE && {rasN, casN, weN} !== PIN_ACTIVATE) fail("activate code");
    if (c == CMD_READ && dataBusFree !== 1'b0) fail("bus free after read");
    if (c == CMD_SELFREF_ENTER || c == CMD_POWERDOWN_ENTER) expCke = 1'b0;
    if (c == CMD_SELFREF_EXIT || c == CMD_POWERDOWN_EXIT) expCke = 1'b1;
    if (gap > 0) compares++;
    if (n == 400 || (gap > 0 && n != gap)) fail("command spacing");
  endtask
  task automatic idle();
    cmdValid <= 1'b0;
    cmdCode  <= CMD_NOP;
    @(posedge clk);
  endtask
  // ------
  // Scenarios
  // ------
  // Burst eight: mode set spacing and bank turnarounds, all-bank precharge
  task automatic t_bank_gaps();
    issue(CMD_MODE_SET, 2'h0, 13'h0002, 0);
    issue(CMD_MODE_SET, 2'h0, 13'h0003, 2);
    issue(CMD_ACTIVATE, 2'h1, 13'h0000, 2);
    issue(CMD_WRITE, 2'h1, 13'h0000, 0);
    issue(CMD_READ, 2'h1, 13'h0000, 6);
    issue(CMD_WRITE, 2'h2, 13'h0000, 6);
    issue(CMD_PRECHARGE, 2'h0, 13'h0400, 7);
    issue(CMD_READ, 2'h3, 13'h0000, 0);
    issue(CMD_PRECHARGE, 2'h3, 13'h0000, 4);
    idle();
  endtask
  // Self refresh and power down exits
  task automatic t_power();
    issue(CMD_SELFREF_ENTER, 2'h0, 13'h0000, 0);
    issue(CMD_SELFREF_EXIT, 2'h0, 13'h0000, 2);
    issue(CMD_ACTIVATE, 2'h0, 13'h0000, 10);
    issue(CMD_READ, 2'h0, 13'h0000, 190);
    issue(CMD_POWERDOWN_ENTER, 2'h0, 13'h0000, 0);
    issue(CMD_POWERDOWN_EXIT, 2'h0, 13'h0000, 2);
    issue(CMD_ACTIVATE, 2'h1, 13'h0000, 2);
    idle();
  endtask
  // Burst stop and turnarounds after a reset, burst two
  task automatic t_stop(input logic lh);
    do_reset(lh);
    issue(CMD_READ, 2'h0, 13'h0000, 0);
    issue(CMD_BURST_STOP, 2'h0, 13'h0000, 0);
    issue(CMD_WRITE, 2'h0, 13'h0000, 2 + lh);
    issue(CMD_READ, 2'h0, 13'h0000, 3);
    issue(CMD_WRITE, 2'h0, 13'h0000, 3 + lh);
    idle();
  endtask
  // Write data launched while read data still drives would clash
  always @(negedge clk) begin
    if (wrDataStart === 1'b1) compares++;
    if (wrDataStart === 1'b1 && dqOe !== 1'b0) fail("data bus clash");
    if (wrDataStart !== wrCapture) fail("write data latency");
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail("watchdog");
    finish_test();
  end
  initial begin
    expCke = 1'b1;
    cmdBank <= 2'h0;
    cmdAddr <= 13'h0000;
    do_reset(1'b0);
    t_bank_gaps();
    t_power();
    t_stop(1'b0);
    t_stop(1'b1);
    finish_test();
  end
endmodule // tb
